//--- hw/dm_device.sv
// Purpose: Device end: indirect data memory window, calibration gains, programming status.
// Assumes: Mode, lock and measurement inputs come from logic on sys_clk_in.
// Notes: Window covers DM_WIN_BYTES bytes from DM_GAIN_BASE plus the status record.
// How it works
// - OK bit 7 only when no fault
// - Lock bit 5 when not both modes
// - Bit 4 when signature writes exhausted
// - Bit 3 when no XOR bits; address follows
// - Bit 2 when die too hot
// - Bit 1 when stack below minimum
// - Bit 0 when stack above maximum
// - Memory reached like subcommands, by address
// - Host writes address bytes to mem_address_low/mem_address_high
// - Little-endian buffer 0x40-0x5F, 32 bytes max
// - Host writes checksum then length last
// - Length equals data bytes plus four
// - Checksum covers address and data only
// - Read fills 32 bytes, length 0x24
// - Host verifies by reading length, data, checksum
// - Signed gain, zero picks factory value
// - Update mode shows programmed, else used
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "dm_params.svh"
module dm_device import dm_pkg::*; #(
  parameter int NCELL = 5,
  parameter word_t TEMP_MAX = 16'h0400,
  parameter word_t STACK_MIN = 16'h2000,
  parameter word_t STACK_MAX = 16'h8000
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Host link
  dm_link_if.device lnk,
  // Modes and programming conditions
  input wire logic config_update_in,
  input wire logic unrestricted_security_mode_in,
  input wire logic otp_lock_in,
  input wire logic signature_write_failed_in,
  input wire logic data_write_failed_in,
  input wire logic [15:0] fail_param_addr_in,
  input wire logic [15:0] die_temp_in,
  input wire logic [15:0] stack_mv_in,
  // Calibration
  input wire logic [NCELL*16-1:0] factory_gain_in,
  output logic [NCELL*16-1:0] eff_gain_out,
  // Status
  output logic [7:0] otp_result_out,
  output logic commit_ok_out,
  output logic commit_err_out
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  byte_t mem_q [`DM_WIN_BYTES];
  byte_t buf_q [`DM_BUF_BYTES];
  byte_t alo_q, ahi_q, sum_q, len_q, rdata_q;
  byte_t status_q;
  word_t fail_addr_q;
  logic commit_ok_q, commit_err_q;
  byte_t view [`DM_WIN_BYTES];
  byte_t new_mem [`DM_WIN_BYTES];
  byte_t fill_sum;
  byte_t wr_sum;
  logic len_ok, sum_ok, range_ok;
  word_t fill_addr;
  word_t wr_addr;
  logic [7:0] nbytes;

  // --------------------------------------------------------------------------
  // Gain view
  // --------------------------------------------------------------------------
  for (genvar c = 0; c < NCELL; c++) begin : g_gain
    word_t prog;
    word_t eff;
    assign prog = {mem_q[2*c+1], mem_q[2*c]};
    assign eff = (prog == `DM_GAIN_RESET) ? factory_gain_in[c*16 +: 16] : prog;
    assign eff_gain_out[c*16 +: 16] = eff;
  end

  always_comb begin
    for (int j = 0; j < `DM_WIN_BYTES; j++) begin
      view[j] = mem_q[j];
      if (j < 2 * NCELL && !config_update_in) begin
        view[j] = (j % 2 == 0) ? eff_gain_out[(j/2)*16 +: 8] : eff_gain_out[(j/2)*16+8 +: 8];
      end
    end
  end

  // Byte of data memory as the host sees it, by full 16-bit address.
  function automatic byte_t dm_byte(input word_t a);
    word_t off;
    off = a - `DM_GAIN_BASE;
    if (off < 16'(`DM_WIN_BYTES)) begin
      return view[off[4:0]];
    end else if (a == `DM_OTP_RESULT_ADDR) begin
      return status_q;
    end else if (a == `DM_OTP_RESULT_ADDR + 16'h0001) begin
      return fail_addr_q[7:0];
    end else if (a == `DM_OTP_RESULT_ADDR + 16'h0002) begin
      return fail_addr_q[15:8];
    end
    return 8'h00;
  endfunction

  // --------------------------------------------------------------------------
  // Read fill and write commit arithmetic
  // --------------------------------------------------------------------------
  assign fill_addr = {lnk.wdata, alo_q};
  assign wr_addr = {ahi_q, alo_q};
  assign nbytes = lnk.wdata - `DM_LEN_EXTRA;
  assign len_ok = (lnk.wdata >= `DM_LEN_MIN) && (lnk.wdata <= `DM_LEN_MAX);

  always_comb begin
    byte_t acc;
    acc = alo_q + lnk.wdata;
    for (int i = 0; i < `DM_BUF_BYTES; i++) begin
      acc = acc + dm_byte(fill_addr + 16'(i));
    end
    fill_sum = ~acc;
  end

  always_comb begin
    byte_t acc;
    acc = alo_q + ahi_q;
    for (int i = 0; i < `DM_BUF_BYTES; i++) begin
      if (8'(i) < nbytes) begin
        acc = acc + buf_q[i];
      end
    end
    wr_sum = ~acc;
  end
  assign sum_ok = (wr_sum == sum_q);

  always_comb begin
    word_t d;
    d = 16'h0000;
    for (int j = 0; j < `DM_WIN_BYTES; j++) begin
      d = `DM_GAIN_BASE + 16'(j) - wr_addr;
      new_mem[j] = (d < {8'h00, nbytes}) ? buf_q[d[4:0]] : mem_q[j];
    end
    range_ok = 1'b1;
    for (int c = 0; c < NCELL; c++) begin
      if ({new_mem[2*c+1], new_mem[2*c]} == `DM_GAIN_FORBIDDEN) begin
        range_ok = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Window registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
      sum_q <= 8'h00;
      len_q <= 8'h00;
      for (int i = 0; i < `DM_BUF_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (lnk.wr) begin
      if (lnk.addr == `DM_ADDR_LO_OFS) begin
        alo_q <= lnk.wdata;
      end else if (lnk.addr == `DM_ADDR_HI_OFS) begin
        ahi_q <= lnk.wdata;
        for (int i = 0; i < `DM_BUF_BYTES; i++) begin
          buf_q[i] <= dm_byte(fill_addr + 16'(i));
        end
        sum_q <= fill_sum;
        len_q <= `DM_READ_LEN;
      end else if (lnk.addr >= `DM_BUF_OFS && lnk.addr <= `DM_BUF_LAST_OFS) begin
        buf_q[lnk.addr[4:0]] <= lnk.wdata;
      end else if (lnk.addr == `DM_SUM_OFS) begin
        sum_q <= lnk.wdata;
      end else if (lnk.addr == `DM_LEN_OFS) begin
        len_q <= lnk.wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Data memory commit
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      for (int j = 0; j < `DM_WIN_BYTES; j++) begin
        mem_q[j] <= 8'h00;
      end
      commit_ok_q <= 1'b0;
      commit_err_q <= 1'b0;
    end else begin
      commit_ok_q <= 1'b0;
      commit_err_q <= 1'b0;
      if (lnk.wr && lnk.addr == `DM_LEN_OFS) begin
        if (len_ok && sum_ok && range_ok) begin
          for (int j = 0; j < `DM_WIN_BYTES; j++) begin
            mem_q[j] <= new_mem[j];
          end
          commit_ok_q <= 1'b1;
        end else begin
          commit_err_q <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Programming result
  // --------------------------------------------------------------------------
  logic locked, hot, low, high, fault;
  assign locked = !(unrestricted_security_mode_in && config_update_in) || otp_lock_in;
  assign hot = die_temp_in > TEMP_MAX;
  assign low = stack_mv_in < STACK_MIN;
  assign high = stack_mv_in > STACK_MAX;
  assign fault = locked | signature_write_failed_in | data_write_failed_in | hot | low | high;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      status_q <= 8'h00;
      fail_addr_q <= 16'h0000;
    end else begin
      status_q <= 8'h00;
      status_q[`OTP_OK_BIT] <= !fault;
      status_q[`OTP_LOCK_BIT] <= locked;
      status_q[`OTP_SIG_BIT] <= signature_write_failed_in;
      status_q[`OTP_DATA_BIT] <= data_write_failed_in;
      status_q[`OTP_HOT_BIT] <= hot;
      status_q[`OTP_LV_BIT] <= low;
      status_q[`OTP_HV_BIT] <= high;
      fail_addr_q <= data_write_failed_in ? fail_param_addr_in : 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // Link read data
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_q <= 8'h00;
    end else if (lnk.rd) begin
      if (lnk.addr == `DM_ADDR_LO_OFS) begin
        rdata_q <= alo_q;
      end else if (lnk.addr == `DM_ADDR_HI_OFS) begin
        rdata_q <= ahi_q;
      end else if (lnk.addr >= `DM_BUF_OFS && lnk.addr <= `DM_BUF_LAST_OFS) begin
        rdata_q <= buf_q[lnk.addr[4:0]];
      end else if (lnk.addr == `DM_SUM_OFS) begin
        rdata_q <= sum_q;
      end else if (lnk.addr == `DM_LEN_OFS) begin
        rdata_q <= len_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign lnk.rdata = rdata_q;
  assign otp_result_out = status_q;
  assign commit_ok_out = commit_ok_q;
  assign commit_err_out = commit_err_q;

endmodule

//--- hw/dm_host.sv
// Purpose: Host end: runs block writes and read-back checks over the byte link.
// Assumes: Software drives the plain command port on sys_clk_in.
// Notes: Registers at HC_* offsets; staging buffer at HC_BUF_OFS.
`timescale 1ns/1ps
`include "dm_params.svh"
module dm_host import dm_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Software port
  input wire logic [7:0] sw_addr_in,
  input wire logic [7:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [7:0] sw_rdata_out,
  // Device link
  dm_link_if.host lnk
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  host_state_t st_q;
  read_kind_t kind_q;
  byte_t stage_q [`DM_BUF_BYTES];
  byte_t alo_q, ahi_q, cnt_q, idx_q, acc_q, rdata_q;
  byte_t l_addr_q, l_wdata_q;
  logic l_wr_q, l_rd_q, op_rd_q, ok_q, err_q;
  logic start_wr, start_rd;
  logic busy;

  assign busy = (st_q != H_IDLE);
  assign start_wr = sw_wr_in && sw_addr_in == `HC_CTRL_OFS && !busy
                    && sw_wdata_in[`HC_START_WR_BIT];
  assign start_rd = sw_wr_in && sw_addr_in == `HC_CTRL_OFS && !busy
                    && !sw_wdata_in[`HC_START_WR_BIT] && sw_wdata_in[`HC_START_RD_BIT];

  // --------------------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_q <= H_IDLE;
      kind_q <= RK_LEN;
      idx_q <= 8'h00;
      acc_q <= 8'h00;
      op_rd_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      l_addr_q <= 8'h00;
      l_wdata_q <= 8'h00;
      l_wr_q <= 1'b0;
      l_rd_q <= 1'b0;
      for (int i = 0; i < `DM_BUF_BYTES; i++) begin
        stage_q[i] <= 8'h00;
      end
    end else begin
      l_wr_q <= 1'b0;
      l_rd_q <= 1'b0;
      if (sw_wr_in && !busy && sw_addr_in >= `HC_BUF_OFS
          && sw_addr_in < `HC_BUF_OFS + 8'(`DM_BUF_BYTES)) begin
        stage_q[sw_addr_in[4:0]] <= sw_wdata_in;
      end
      case (st_q)
        H_IDLE: begin
          if (start_wr || start_rd) begin
            ok_q <= 1'b0;
            err_q <= 1'b0;
            op_rd_q <= start_rd;
            if (start_wr && (cnt_q == 8'h00 || cnt_q > 8'(`DM_BUF_BYTES))) begin
              err_q <= 1'b1;
            end else begin
              st_q <= H_ALO;
            end
          end
        end
        H_ALO: begin
          l_wr_q <= 1'b1;
          l_addr_q <= `DM_ADDR_LO_OFS;
          l_wdata_q <= alo_q;
          acc_q <= alo_q;
          st_q <= H_AHI;
        end
        H_AHI: begin
          l_wr_q <= 1'b1;
          l_addr_q <= `DM_ADDR_HI_OFS;
          l_wdata_q <= ahi_q;
          acc_q <= acc_q + ahi_q;
          idx_q <= 8'h00;
          kind_q <= RK_LEN;
          st_q <= op_rd_q ? H_RISSUE : H_WDAT;
        end
        H_WDAT: begin
          l_wr_q <= 1'b1;
          l_addr_q <= `DM_BUF_OFS + idx_q;
          l_wdata_q <= stage_q[idx_q[4:0]];
          acc_q <= acc_q + stage_q[idx_q[4:0]];
          idx_q <= idx_q + 8'h01;
          if (idx_q + 8'h01 == cnt_q) begin
            st_q <= H_WSUM;
          end
        end
        H_WSUM: begin
          l_wr_q <= 1'b1;
          l_addr_q <= `DM_SUM_OFS;
          l_wdata_q <= ~acc_q;
          st_q <= H_WLEN;
        end
        H_WLEN: begin
          l_wr_q <= 1'b1;
          l_addr_q <= `DM_LEN_OFS;
          l_wdata_q <= cnt_q + `DM_LEN_EXTRA;
          ok_q <= 1'b1;
          st_q <= H_IDLE;
        end
        H_RISSUE: begin
          l_rd_q <= 1'b1;
          if (kind_q == RK_LEN) begin
            l_addr_q <= `DM_LEN_OFS;
          end else if (kind_q == RK_DATA) begin
            l_addr_q <= `DM_BUF_OFS + idx_q;
          end else begin
            l_addr_q <= `DM_SUM_OFS;
          end
          st_q <= H_RWAIT;
        end
        H_RWAIT: begin
          st_q <= H_RCAP;
        end
        H_RCAP: begin
          st_q <= H_RISSUE;
          if (kind_q == RK_LEN) begin
            if (lnk.rdata < `DM_LEN_MIN || lnk.rdata > `DM_LEN_MAX) begin
              err_q <= 1'b1;
              st_q <= H_IDLE;
            end else begin
              kind_q <= RK_DATA;
            end
          end else if (kind_q == RK_DATA) begin
            stage_q[idx_q[4:0]] <= lnk.rdata;
            acc_q <= acc_q + lnk.rdata;
            idx_q <= idx_q + 8'h01;
            if (idx_q + 8'h01 == cnt_q) begin
              kind_q <= RK_SUM;
            end
          end else begin
            ok_q <= (~acc_q == lnk.rdata);
            err_q <= (~acc_q != lnk.rdata);
            st_q <= H_IDLE;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
      cnt_q <= 8'h00;
    end else if (st_q == H_RCAP && kind_q == RK_LEN) begin
      cnt_q <= lnk.rdata - `DM_LEN_EXTRA;
    end else if (sw_wr_in && !busy) begin
      if (sw_addr_in == `HC_ALO_OFS) begin
        alo_q <= sw_wdata_in;
      end else if (sw_addr_in == `HC_AHI_OFS) begin
        ahi_q <= sw_wdata_in;
      end else if (sw_addr_in == `HC_CNT_OFS) begin
        cnt_q <= sw_wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_q <= 8'h00;
    end else if (sw_rd_in) begin
      if (sw_addr_in == `HC_STAT_OFS) begin
        rdata_q <= {5'b00000, err_q, ok_q, busy};
      end else if (sw_addr_in == `HC_ALO_OFS) begin
        rdata_q <= alo_q;
      end else if (sw_addr_in == `HC_AHI_OFS) begin
        rdata_q <= ahi_q;
      end else if (sw_addr_in == `HC_CNT_OFS) begin
        rdata_q <= cnt_q;
      end else if (sw_addr_in >= `HC_BUF_OFS && sw_addr_in < `HC_BUF_OFS + 8'(`DM_BUF_BYTES)) begin
        rdata_q <= stage_q[sw_addr_in[4:0]];
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign sw_rdata_out = rdata_q;
  assign lnk.addr = l_addr_q;
  assign lnk.wdata = l_wdata_q;
  assign lnk.wr = l_wr_q;
  assign lnk.rd = l_rd_q;

endmodule

//--- hw/dm_link_if.sv
// Purpose: Byte register link between host and device.
// Assumes: One clock; read data stand one cycle after the read strobe.
// Notes: Host drives address, data and strobes; device drives read data.
`timescale 1ns/1ps
interface dm_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

//--- hw/dm_params.svh
// Purpose: Offsets, field positions, reset values and counts for the data memory window.
// Assumes: Included by both link ends; definitions only.
// Notes: Host-side command register offsets are listed at the bottom.
`ifndef DM_PARAMS_SVH
`define DM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Link window offsets
// ----------------------------------------------------------------------------
`define DM_ADDR_LO_OFS 8'h3E
`define DM_ADDR_HI_OFS 8'h3F
`define DM_BUF_OFS 8'h40
`define DM_BUF_LAST_OFS 8'h5F
`define DM_SUM_OFS 8'h60
`define DM_LEN_OFS 8'h61
`define DM_BUF_BYTES 32
`define DM_LEN_EXTRA 8'h04
`define DM_LEN_MIN 8'h05
`define DM_LEN_MAX 8'h24
`define DM_READ_LEN 8'h24

// ----------------------------------------------------------------------------
// Data memory map
// ----------------------------------------------------------------------------
`define DM_GAIN_BASE 16'h9180
`define DM_WIN_BYTES 32
`define DM_OTP_RESULT_ADDR 16'h00A0
`define DM_GAIN_RESET 16'h0000
`define DM_GAIN_FORBIDDEN 16'h8000

// ----------------------------------------------------------------------------
// Programming result bits
// ----------------------------------------------------------------------------
`define OTP_OK_BIT 7
`define OTP_LOCK_BIT 5
`define OTP_SIG_BIT 4
`define OTP_DATA_BIT 3
`define OTP_HOT_BIT 2
`define OTP_LV_BIT 1
`define OTP_HV_BIT 0

// ----------------------------------------------------------------------------
// Host command registers
// ----------------------------------------------------------------------------
`define HC_CTRL_OFS 8'h00
`define HC_STAT_OFS 8'h01
`define HC_ALO_OFS 8'h02
`define HC_AHI_OFS 8'h03
`define HC_CNT_OFS 8'h04
`define HC_BUF_OFS 8'h20
`define HC_START_WR_BIT 0
`define HC_START_RD_BIT 1

`endif

//--- hw/dm_pkg.sv
// Purpose: Shared types for the data memory window ends.
// Assumes: Constants live in dm_params.svh.
// Notes: None.
package dm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {RK_LEN, RK_DATA, RK_SUM} read_kind_t;
  typedef enum logic [3:0] {
    H_IDLE, H_ALO, H_AHI, H_WDAT, H_WSUM, H_WLEN, H_RISSUE, H_RWAIT, H_RCAP
  } host_state_t;
endpackage

//--- sim/dm_link_properties.sv
// Purpose: Protocol checks on the byte link between host and device.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees only the link signals.
`timescale 1ns/1ps
module dm_link_properties (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Link
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  logic [7:0] cnt_q;
  logic [7:0] sum_q;
  logic buf_wr;
  assign buf_wr = wr && addr >= 8'h40 && addr <= 8'h5F;
  // Counts buffer bytes written since the high address byte.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || (wr && addr == 8'h3F)) begin
      cnt_q <= 8'h00;
    end else if (buf_wr) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Sums the address bytes and the buffer bytes of a block write.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sum_q <= 8'h00;
    end else if (wr && addr == 8'h3E) begin
      sum_q <= wdata;
    end else if (buf_wr || (wr && addr == 8'h3F)) begin
      sum_q <= sum_q + wdata;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  property p_lo_hi; wr && addr == 8'h3F |-> $past(wr) && $past(addr) == 8'h3E; endproperty
  a_lo_hi: assert property (p_lo_hi) else $error("high address byte without low");
  property p_buf; buf_wr |-> addr == 8'h40 + cnt_q && cnt_q < 8'h20; endproperty
  a_buf: assert property (p_buf) else $error("buffer byte out of order");
  property p_sum_len; wr && addr == 8'h61 |-> $past(wr) && $past(addr) == 8'h60; endproperty
  a_sum_len: assert property (p_sum_len) else $error("length not after checksum");
  property p_len_val; wr && addr == 8'h61 |-> wdata == cnt_q + 8'h04; endproperty
  a_len_val: assert property (p_len_val) else $error("length byte wrong");
  property p_sum_val; wr && addr == 8'h60 |-> wdata == ~sum_q; endproperty
  a_sum_val: assert property (p_sum_val) else $error("checksum byte wrong");
  property p_len_rd; rd && addr == 8'h61 |=> rdata == 8'h24; endproperty
  a_len_rd: assert property (p_len_rd) else $error("read length not 0x24");
  property p_rd_space; rd |=> !rd [*2]; endproperty
  a_rd_space: assert property (p_rd_space) else $error("reads too close");
  property p_hold; !rd |=> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without read");
  c_commit: cover property (wr && addr == 8'h61);
  c_rdlen: cover property (rd && addr == 8'h61);
  c_rdsum: cover property (rd && addr == 8'h60);
endmodule

//--- sim/tb.sv
// Purpose: Self-checking bench for host and device joined by the link.
// Assumes: Software port driven by non-blocking assignment after rising edges.
// Notes: Status byte is {err, ok, busy} in bits 2..0.
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] TMAX = 16'h0400;
  localparam logic [15:0] SMIN = 16'h2000;
  localparam logic [15:0] SMAX = 16'h8000;
  localparam logic [79:0] FACT = 80'h5005_4004_3003_2002_1001;
  logic sys_clk_in;
  logic srst_in;
  logic [7:0] sw_addr;
  logic [7:0] sw_wdata;
  logic [7:0] rdata_sw;
  logic sw_wr;
  logic sw_rd;
  logic cfg, unr, lock, sig, dat;
  logic [15:0] fail_addr, temp, stack;
  logic [79:0] eff;
  logic [7:0] res;
  logic c_ok, c_err;
  logic [7:0] v;
  logic [7:0] exp_res [8] = '{8'h80, 8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  int miscompares = 0;
  int tests_run = 0;
  int n_ok = 0;
  int n_err = 0;
  int cyc = 0;
  int k;
  dm_link_if lnk();
  dm_host u_dm_host (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
    .sw_rdata_out(rdata_sw), .lnk(lnk)
  );
  dm_device #(.NCELL(5), .TEMP_MAX(TMAX), .STACK_MIN(SMIN), .STACK_MAX(SMAX)) u_dm_device (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .lnk(lnk), .config_update_in(cfg),
    .unrestricted_security_mode_in(unr), .otp_lock_in(lock),
    .signature_write_failed_in(sig), .data_write_failed_in(dat),
    .fail_param_addr_in(fail_addr), .die_temp_in(temp), .stack_mv_in(stack),
    .factory_gain_in(FACT), .eff_gain_out(eff), .otp_result_out(res),
    .commit_ok_out(c_ok), .commit_err_out(c_err)
  );
  dm_link_properties u_dm_link_properties (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .addr(lnk.addr), .wdata(lnk.wdata),
    .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata)
  );
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // Counts commit pulses and cuts a hang short.
  always @(posedge sys_clk_in) begin
    cyc++;
    if (c_ok === 1'b1) n_ok++;
    if (c_err === 1'b1) n_err++;
    if (cyc == 30000) begin
      miscompares++;
      summarize();
    end
  end
  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk_in);
    sw_wr <= 1'b0;
  endtask
  task automatic srd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk_in);
    sw_rd <= 1'b0;
    #1;
    d = rdata_sw;
  endtask
  task automatic wait_idle();
    int i;
    logic [7:0] s;
    for (i = 0; i < 300; i++) begin
      srd(8'h01, s);
      if (s[0] === 1'b0) break;
    end
    if (i == 300) miscompares++;
  endtask
  task automatic hwrite(input logic [15:0] a, input logic [15:0] d);
    swr(8'h20, d[7:0]);
    swr(8'h21, d[15:8]);
    swr(8'h02, a[7:0]);
    swr(8'h03, a[15:8]);
    swr(8'h04, 8'h02);
    swr(8'h00, 8'h01);
    wait_idle();
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic hverify(input logic [15:0] a);
    swr(8'h02, a[7:0]);
    swr(8'h03, a[15:8]);
    swr(8'h00, 8'h02);
    wait_idle();
    srd(8'h01, v);
    check(v, 8'h02);
    srd(8'h04, v);
    check(v, 8'h20);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    srst_in = 1'b1;
    sw_addr = 8'h00;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    {cfg, unr, lock, sig, dat} = 5'b11000;
    fail_addr = 16'h1234;
    temp = TMAX;
    stack = SMIN;
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    check(eff[15:0], FACT[15:0]);
    for (k = 0; k < 8; k++) begin
      @(posedge sys_clk_in);
      lock <= (k == 1);
      cfg <= (k != 2);
      sig <= (k == 3);
      dat <= (k == 4);
      temp <= (k == 5) ? TMAX + 16'h0001 : TMAX;
      stack <= (k == 6) ? SMIN - 16'h0001 : ((k == 7) ? SMAX + 16'h0001 : SMIN);
      repeat (2) @(posedge sys_clk_in);
      #1;
      check(res, exp_res[k]);
    end
    @(posedge sys_clk_in);
    stack <= SMIN;
    dat <= 1'b1;
    hverify(16'h00A0);
    srd(8'h20, v);
    check(v, 8'h08);
    srd(8'h21, v);
    check(v, 8'h34);
    srd(8'h22, v);
    check(v, 8'h12);
    @(posedge sys_clk_in);
    dat <= 1'b0;
    hwrite(16'h9180, 16'h307A);
    check(n_ok[15:0], 16'h0001);
    check(eff[31:0], {FACT[31:16], 16'h307A});
    hverify(16'h9180);
    srd(8'h20, v);
    check(v, 8'h7A);
    srd(8'h21, v);
    check(v, 8'h30);
    srd(8'h22, v);
    check(v, 8'h00);
    @(posedge sys_clk_in);
    cfg <= 1'b0;
    hverify(16'h9180);
    srd(8'h22, v);
    check(v, 8'h02);
    srd(8'h23, v);
    check(v, 8'h20);
    @(posedge sys_clk_in);
    cfg <= 1'b1;
    hwrite(16'h9180, 16'h8000);
    check(n_err[15:0], 16'h0001);
    check(eff[15:0], 16'h307A);
    hwrite(16'h9180, 16'h0000);
    check(eff[15:0], FACT[15:0]);
    foreach (exp_res[j]) begin
      if (j < 2) begin
        swr(8'h04, (j == 0) ? 8'h00 : 8'h21);
        swr(8'h00, 8'h01);
        wait_idle();
        srd(8'h01, v);
        check(v, 8'h04);
      end
    end
    check(n_ok[15:0], 16'h0002);
    summarize();
  end
endmodule
